// ### hdl/sar_adc_conversion_sequencer.sv
// Conversion sequencer of an 8-bit successive-approximation converter with AHB-Lite registers
// Summary of operation
// - Once enabled, conversions repeat back to back until software clears enable.
// - Mode or select write during conversion aborts it; restart from start if enabled.
// - Select mode only: select register picks one of six analog inputs.
// - Only a software write of enable=1 starts conversion; no hardware trigger.
// - Each completion loads result register and raises completion request together.
// - Mode write with enable=1 mid-conversion restarts with the new settings.
// - Mode write with enable=0 mid-conversion stops at once, no completion.
// - Code is int(vin/vref*256+0.5); ladder offset gives half-step rounding.
// - Result read colliding with completion returns old value; new one stored after.
// - Mode/select write colliding with completion wins: no result update, no request.
// - Standby halts all conversion activity.
// - Mode register writes never touch the completion flag.
// - Reset leaves the result register contents undefined.
// - Time select 000/001/010/100 gives 144/120/96/72 clocks per conversion.
// - Mode register: enable bit 7, time select bits 5..3, resets to zero.
// - Select register bits 2..0 code channels 0..5, resets to zero.
// - Bits resolved MSB first; trial bit kept when input at or above level.
//
// Our own choices: the AHB-Lite slave port and the register addresses.
`timescale 1ns/1ps

module sar_adc_conversion_sequencer (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic cmp_ge,
  input wire logic standby,
  output sar_seq_pkg::analog_ctrl_type analog_ctrl,
  output logic conversion_done_irq,
  output logic converter_busy
);

  // Whole block state
  typedef struct packed {
    logic conversion_enable_bit;
    logic [2:0] conv_time_select;
    logic [2:0] channel_select;
    logic [7:0] conversion_result_reg;
    logic [7:0] approximation_shift_reg;
    sar_seq_pkg::phase_type phase;
    logic [7:0] cycle_cnt;
    logic [2:0] bit_idx;
    logic conversion_done_flag;
    logic irq;
    logic sampling;
    logic busy;
    logic dp_write;
    sar_seq_pkg::reg_id_type dp_reg;
    logic [31:0] rdata;
    logic readyout;
  } state_type;

  state_type cur_ff;
  state_type nxt_ff;

  // Address decode, used for both read and write
  function automatic sar_seq_pkg::reg_id_type decode_addr(input logic [31:0] addr);
    unique case (addr)
      sar_seq_pkg::MODE_ADDR: decode_addr = sar_seq_pkg::REG_MODE;
      sar_seq_pkg::SELECT_ADDR: decode_addr = sar_seq_pkg::REG_SELECT;
      sar_seq_pkg::RESULT_ADDR: decode_addr = sar_seq_pkg::REG_RESULT;
      sar_seq_pkg::STATUS_ADDR: decode_addr = sar_seq_pkg::REG_STATUS;
      default: decode_addr = sar_seq_pkg::REG_NONE;
    endcase
  endfunction : decode_addr

  // Length of one slot in clocks for a time-select code
  function automatic logic [7:0] step_len(input logic [2:0] tsel);
    unique case (tsel)
      sar_seq_pkg::TSEL_120: step_len = sar_seq_pkg::STEP_120;
      sar_seq_pkg::TSEL_96: step_len = sar_seq_pkg::STEP_96;
      sar_seq_pkg::TSEL_72: step_len = sar_seq_pkg::STEP_72;
      default: step_len = sar_seq_pkg::STEP_144;
    endcase
  endfunction : step_len

  logic acc;
  logic wr_mode;
  logic wr_select;
  logic wr_status;
  logic abort;
  logic last_step;
  logic done;
  logic [7:0] resolved;
  logic [7:0] step;
  logic [7:0] read_byte;

  // Bus access decode and write strobes in the data phase
  assign acc = hsel & htrans[1] & hready;
  assign wr_mode = cur_ff.dp_write & (cur_ff.dp_reg == sar_seq_pkg::REG_MODE);
  assign wr_select = cur_ff.dp_write & (cur_ff.dp_reg == sar_seq_pkg::REG_SELECT);
  assign wr_status = cur_ff.dp_write & (cur_ff.dp_reg == sar_seq_pkg::REG_STATUS);
  assign abort = wr_mode | wr_select;

  // Current step decision and completion
  assign step = step_len(cur_ff.conv_time_select);
  assign last_step = (cur_ff.phase == sar_seq_pkg::PH_CONVERT) && (cur_ff.cycle_cnt == 8'h00);
  always_comb begin
    resolved = cur_ff.approximation_shift_reg;
    if (!cmp_ge) begin
      resolved[cur_ff.bit_idx] = 1'b0;
    end
  end
  assign done = last_step & (cur_ff.bit_idx == 3'h0) & ~abort & ~standby;

  // Read multiplexer
  always_comb begin
    unique case (decode_addr(haddr))
      sar_seq_pkg::REG_MODE: begin
        read_byte = {cur_ff.conversion_enable_bit, 1'b0, cur_ff.conv_time_select, 3'h0};
      end
      sar_seq_pkg::REG_SELECT: read_byte = {5'h00, cur_ff.channel_select};
      sar_seq_pkg::REG_RESULT: read_byte = cur_ff.conversion_result_reg;
      sar_seq_pkg::REG_STATUS: read_byte = {6'h00, cur_ff.busy, cur_ff.conversion_done_flag};
      default: read_byte = 8'h00;
    endcase
  end

  // Next-state logic
  always_comb begin
    nxt_ff = cur_ff;
    nxt_ff.irq = 1'b0;
    nxt_ff.readyout = 1'b1;

    // Address phase capture; read data is taken before any completion update
    nxt_ff.dp_write = acc & hwrite;
    nxt_ff.dp_reg = acc ? decode_addr(haddr) : sar_seq_pkg::REG_NONE;
    if (acc && !hwrite) begin
      nxt_ff.rdata = {24'h00_0000, read_byte};
    end

    // Sequencer
    unique case (cur_ff.phase)
      sar_seq_pkg::PH_IDLE: begin
        if (cur_ff.conversion_enable_bit) begin
          nxt_ff.phase = sar_seq_pkg::PH_SAMPLE;
          nxt_ff.cycle_cnt = 8'(step * sar_seq_pkg::SAMPLE_SLOTS - 1);
          nxt_ff.approximation_shift_reg = 8'h00;
        end
      end
      sar_seq_pkg::PH_SAMPLE: begin
        if (cur_ff.cycle_cnt == 8'h00) begin
          nxt_ff.phase = sar_seq_pkg::PH_CONVERT;
          nxt_ff.bit_idx = sar_seq_pkg::TOP_BIT;
          nxt_ff.approximation_shift_reg = sar_seq_pkg::APPROX_MSB_TRIAL;
          nxt_ff.cycle_cnt = 8'(step - 1);
        end else begin
          nxt_ff.cycle_cnt = 8'(cur_ff.cycle_cnt - 1);
        end
      end
      sar_seq_pkg::PH_CONVERT: begin
        if (cur_ff.cycle_cnt != 8'h00) begin
          nxt_ff.cycle_cnt = 8'(cur_ff.cycle_cnt - 1);
        end else if (cur_ff.bit_idx != 3'h0) begin
          // Comparator taken once per step, then next trial bit set
          nxt_ff.approximation_shift_reg = resolved;
          nxt_ff.approximation_shift_reg[cur_ff.bit_idx - 3'h1] = 1'b1;
          nxt_ff.bit_idx = 3'(cur_ff.bit_idx - 3'h1);
          nxt_ff.cycle_cnt = 8'(step - 1);
        end else begin
          // Last bit resolved: start next conversion straight away
          nxt_ff.approximation_shift_reg = resolved;
          nxt_ff.phase = sar_seq_pkg::PH_SAMPLE;
          nxt_ff.cycle_cnt = 8'(step * sar_seq_pkg::SAMPLE_SLOTS - 1);
        end
      end
      default: nxt_ff.phase = sar_seq_pkg::PH_IDLE;
    endcase

    // Completion: result and request in the same edge
    if (done) begin
      nxt_ff.conversion_result_reg = resolved;
      nxt_ff.irq = 1'b1;
    end

    // Disabled conversion or standby stops all conversion activity
    if (!cur_ff.conversion_enable_bit || standby) begin
      nxt_ff.phase = sar_seq_pkg::PH_IDLE;
    end

    // Mode and select writes cancel the running conversion
    if (abort) begin
      nxt_ff.phase = sar_seq_pkg::PH_IDLE;
    end
    if (wr_mode) begin
      nxt_ff.conversion_enable_bit = hwdata[sar_seq_pkg::ENABLE_BIT];
      nxt_ff.conv_time_select = hwdata[sar_seq_pkg::TSEL_MSB:sar_seq_pkg::TSEL_LSB];
    end
    if (wr_select) begin
      nxt_ff.channel_select = hwdata[sar_seq_pkg::CHAN_MSB:0];
    end

    // Completion flag: software clears with a one, a new completion wins
    // Only a status write clears the flag; mode writes leave it alone
    if (wr_status && hwdata[sar_seq_pkg::FLAG_BIT]) begin
      nxt_ff.conversion_done_flag = 1'b0;
    end
    if (done) begin
      nxt_ff.conversion_done_flag = 1'b1;
    end

    // Registered views for the ports
    nxt_ff.sampling = (nxt_ff.phase == sar_seq_pkg::PH_SAMPLE);
    nxt_ff.busy = (nxt_ff.phase != sar_seq_pkg::PH_IDLE);

    // Synchronous reset; result register keeps whatever it held
    if (!nrst) begin
      nxt_ff = '0;
      nxt_ff.conv_time_select = sar_seq_pkg::MODE_RESET[sar_seq_pkg::TSEL_MSB:sar_seq_pkg::TSEL_LSB];
      nxt_ff.channel_select = sar_seq_pkg::SELECT_RESET[sar_seq_pkg::CHAN_MSB:0];
      nxt_ff.conversion_enable_bit = sar_seq_pkg::MODE_RESET[sar_seq_pkg::ENABLE_BIT];
      nxt_ff.phase = sar_seq_pkg::PH_IDLE;
      nxt_ff.dp_reg = sar_seq_pkg::REG_NONE;
      nxt_ff.rdata = sar_seq_pkg::WORD_ZERO;
      nxt_ff.readyout = 1'b1;
      nxt_ff.conversion_result_reg = cur_ff.conversion_result_reg;
    end
  end

  // State register
  always_ff @(posedge clk_sys) begin
    cur_ff <= nxt_ff;
  end

  // Outputs straight from state, hresp tied to okay
  assign hrdata = cur_ff.rdata;
  assign hreadyout = cur_ff.readyout;
  assign hresp = 1'b0;
  assign conversion_done_irq = cur_ff.irq;
  assign converter_busy = cur_ff.busy;
  assign analog_ctrl.sample_hold = cur_ff.sampling;
  assign analog_ctrl.channel = cur_ff.channel_select;
  assign analog_ctrl.trial_code = cur_ff.approximation_shift_reg;

endmodule : sar_adc_conversion_sequencer

// ### hdl/sar_seq_pkg.sv
// Constants, register map and carrier types of the conversion sequencer
package sar_seq_pkg;

  // Register byte addresses on the bus
  localparam logic [31:0] MODE_ADDR = 32'h0000_FF80;
  localparam logic [31:0] SELECT_ADDR = 32'h0000_FF84;
  localparam logic [31:0] RESULT_ADDR = 32'h0000_FF88;
  localparam logic [31:0] STATUS_ADDR = 32'h0000_FF8C;

  // Mode register fields
  localparam int ENABLE_BIT = 7;
  localparam int TSEL_MSB = 5;
  localparam int TSEL_LSB = 3;
  localparam logic [7:0] MODE_RESET = 8'h00;
  // Select register fields
  localparam int CHAN_MSB = 2;
  localparam logic [7:0] SELECT_RESET = 8'h00;
  localparam logic [2:0] CHAN_LAST = 3'h5;
  // Status register fields
  localparam int FLAG_BIT = 0;
  localparam int BUSY_BIT = 1;

  // Time-select codes
  localparam logic [2:0] TSEL_144 = 3'h0;
  localparam logic [2:0] TSEL_120 = 3'h1;
  localparam logic [2:0] TSEL_96 = 3'h2;
  localparam logic [2:0] TSEL_72 = 3'h4;
  // Conversion times in main clock cycles
  localparam int CONV_CYC_144 = 144;
  localparam int CONV_CYC_120 = 120;
  localparam int CONV_CYC_96 = 96;
  localparam int CONV_CYC_72 = 72;
  // One conversion is split into this many equal slots: sampling, then 8 bits
  localparam int SLOTS_PER_CONV = 12;
  localparam int SAMPLE_SLOTS = 4;
  localparam logic [7:0] STEP_144 = 8'(CONV_CYC_144 / SLOTS_PER_CONV);
  localparam logic [7:0] STEP_120 = 8'(CONV_CYC_120 / SLOTS_PER_CONV);
  localparam logic [7:0] STEP_96 = 8'(CONV_CYC_96 / SLOTS_PER_CONV);
  localparam logic [7:0] STEP_72 = 8'(CONV_CYC_72 / SLOTS_PER_CONV);

  // Approximation constants
  localparam logic [7:0] APPROX_MSB_TRIAL = 8'h80;
  localparam logic [2:0] TOP_BIT = 3'h7;
  localparam logic [31:0] WORD_ZERO = 32'h0000_0000;

  // Register identifiers after address decode
  typedef enum logic [2:0] {
    REG_NONE = 3'b000,
    REG_MODE = 3'b001,
    REG_SELECT = 3'b010,
    REG_RESULT = 3'b011,
    REG_STATUS = 3'b100
  } reg_id_type;

  // Sequencer phases
  typedef enum logic [1:0] {
    PH_IDLE = 2'b00,
    PH_SAMPLE = 2'b01,
    PH_CONVERT = 2'b10
  } phase_type;

  // Signals toward the analog front end
  typedef struct packed {
    logic sample_hold;
    logic [2:0] channel;
    logic [7:0] trial_code;
  } analog_ctrl_type;

endpackage : sar_seq_pkg

// ### verification/sar_adc_conversion_sequencer_chk.sv
// Port checks of the conversion sequencer
`timescale 1ns/1ps
module sar_adc_conversion_sequencer_chk (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input logic [31:0] hrdata,
  input logic hreadyout,
  input logic hresp,
  input wire logic standby,
  input sar_seq_pkg::analog_ctrl_type analog_ctrl,
  input logic conversion_done_irq,
  input logic converter_busy
);
  logic take;
  logic rd_take;
  logic wr_mode_ff;
  logic wr_sel_ff;
  logic en_ff;
  // Accepted address phases
  assign take = hsel && htrans[1] && hready;
  assign rd_take = take && !hwrite;
  // Mode and select writes in their data phase, last written enable
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      wr_mode_ff <= 1'h0;
      wr_sel_ff <= 1'h0;
      en_ff <= 1'h0;
    end else begin
      wr_mode_ff <= take && hwrite && haddr == sar_seq_pkg::MODE_ADDR;
      wr_sel_ff <= take && hwrite && haddr == sar_seq_pkg::SELECT_ADDR;
      if (wr_mode_ff) begin
        en_ff <= hwdata[sar_seq_pkg::ENABLE_BIT];
      end
    end
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  // Assertions on bus, completion, abort and standby
  chk_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus not ready or not okay");
  chk_irq_pulse: assert property (conversion_done_irq |=> !conversion_done_irq)
    else $error("completion request longer than one cycle");
  chk_start_sw: assert property ($rose(converter_busy) |-> en_ff)
    else $error("conversion started without enable written");
  chk_write_wins: assert property ((wr_mode_ff || wr_sel_ff) |=> !conversion_done_irq [*8])
    else $error("completion request after register write");
  chk_stop_now: assert property (wr_mode_ff && !hwdata[7] |=> ##1 !converter_busy [*4])
    else $error("conversion kept running after disable");
  chk_restart_sample: assert property (wr_mode_ff && hwdata[7] && !standby
    |-> ##[1:3] analog_ctrl.sample_hold)
    else $error("no sampling after enabled mode write");
  chk_standby_idle: assert property (standby [*3] |-> !converter_busy && !conversion_done_irq)
    else $error("activity during standby");
  chk_read_stands: assert property ($changed(hrdata) |-> $past(rd_take))
    else $error("read data changed without a read");
  // Main scenarios reached
  cover property (conversion_done_irq);
  cover property (wr_mode_ff && !hwdata[7]);
  cover property (standby [*3]);
endmodule : sar_adc_conversion_sequencer_chk

bind sar_adc_conversion_sequencer sar_adc_conversion_sequencer_chk i_sar_adc_conversion_sequencer_chk (
  .clk_sys(clk_sys), .nrst(nrst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
  .hreadyout(hreadyout), .hresp(hresp), .standby(standby), .analog_ctrl(analog_ctrl),
  .conversion_done_irq(conversion_done_irq), .converter_busy(converter_busy));

// ### verification/sar_adc_conversion_sequencer_test.sv
// Register-level test of the conversion sequencer with an analog model
`timescale 1ns/1ps
module sar_adc_conversion_sequencer_test;
  localparam logic [47:0] LEVELS = 48'h5AA5_7F80_00FF;
  localparam logic [2:0] CODES [4] = '{sar_seq_pkg::TSEL_144, sar_seq_pkg::TSEL_120,
    sar_seq_pkg::TSEL_96, sar_seq_pkg::TSEL_72};
  localparam int CYCS [4] = '{sar_seq_pkg::CONV_CYC_144, sar_seq_pkg::CONV_CYC_120,
    sar_seq_pkg::CONV_CYC_96, sar_seq_pkg::CONV_CYC_72};
  logic clk_sys = 1'h0;
  logic nrst = 1'h0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'h0;
  logic [31:0] hwdata = 32'h0000_0000;
  logic standby = 1'h0;
  logic hready;
  logic hresp;
  logic cmp_ge;
  logic busy;
  logic done_irq;
  logic [31:0] hrdata;
  logic [31:0] rd;
  logic [31:0] res;
  sar_seq_pkg::analog_ctrl_type actl;
  int mismatches = 0;
  int num_checks = 0;
  int cycles = 0;
  int n;
  always #4 clk_sys = ~clk_sys;
  sar_adc_conversion_sequencer i_sar_adc_conversion_sequencer (.clk_sys(clk_sys),
    .nrst(nrst), .hsel(1'h1), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hready),
    .hresp(hresp), .cmp_ge(cmp_ge), .standby(standby), .analog_ctrl(actl),
    .conversion_done_irq(done_irq), .converter_busy(busy));
  sar_analog_model i_sar_analog_model (.clk_sys(clk_sys), .analog_ctrl(actl),
    .levels(LEVELS), .cmp_ge(cmp_ge));
  task chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // One single transfer; read data taken at the data phase edge
  task xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge clk_sys); while (hready !== 1'h1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk_sys); while (hready !== 1'h1);
    rd = hrdata;
  endtask : xfer
  // Cycles until the next completion request, 400 when none
  task wait_irq();
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (done_irq !== 1'h1 && n < 400);
  endtask : wait_irq
  task end_sim();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : end_sim
  // Hang guard
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      end_sim();
    end
  end
  // Test sequence
  initial begin
    repeat (20) @(posedge clk_sys);
    nrst <= 1'h1;
    @(posedge clk_sys);
    xfer(0, sar_seq_pkg::MODE_ADDR, 0);
    chk(rd, 32'h0000_0000);
    xfer(1, sar_seq_pkg::MODE_ADDR, 32'h0000_0047);
    xfer(0, sar_seq_pkg::MODE_ADDR, 0);
    chk(rd, 32'h0000_0000);
    xfer(0, sar_seq_pkg::SELECT_ADDR, 0);
    chk(rd, 32'h0000_0000);
    xfer(1, sar_seq_pkg::SELECT_ADDR, 32'h0000_00FD);
    xfer(0, sar_seq_pkg::SELECT_ADDR, 0);
    chk(rd, 32'h0000_0005);
    xfer(0, 32'h0000_FF90, 0);
    chk(rd, 32'h0000_0000);
    $display("test reset_map done");
    for (int i = 0; i < 4; i++) begin
      xfer(1, sar_seq_pkg::STATUS_ADDR, 32'h0000_0001);
      xfer(1, sar_seq_pkg::MODE_ADDR, {24'h00_0000, 2'h2, CODES[i], 3'h0});
      wait_irq();
      wait_irq();
      chk(32'(n), 32'(CYCS[i]));
      xfer(0, sar_seq_pkg::RESULT_ADDR, 0);
      chk(rd, {24'h00_0000, LEVELS[47:40]});
      xfer(0, sar_seq_pkg::STATUS_ADDR, 0);
      chk(32'(rd[sar_seq_pkg::FLAG_BIT]), 32'h0000_0001);
    end
    $display("test timing done");
    for (int c = 0; c < 6; c++) begin
      xfer(1, sar_seq_pkg::SELECT_ADDR, 32'(c));
      @(posedge clk_sys);
      chk(32'(actl.channel), 32'(c));
      wait_irq();
      wait_irq();
      xfer(0, sar_seq_pkg::RESULT_ADDR, 0);
      chk(rd, {24'h00_0000, LEVELS[c*8 +: 8]});
    end
    $display("test channels done");
    repeat (30) @(posedge clk_sys);
    xfer(1, sar_seq_pkg::MODE_ADDR, 32'h0000_00A0);
    xfer(0, sar_seq_pkg::STATUS_ADDR, 0);
    chk(32'(rd[sar_seq_pkg::FLAG_BIT]), 32'h0000_0001);
    wait_irq();
    chk(32'(n >= 66 && n <= 76), 32'h0000_0001);
    repeat (30) @(posedge clk_sys);
    xfer(1, sar_seq_pkg::MODE_ADDR, 32'h0000_0020);
    wait_irq();
    chk(32'(n), 32'h0000_0190);
    xfer(1, sar_seq_pkg::STATUS_ADDR, 32'h0000_0001);
    xfer(0, sar_seq_pkg::STATUS_ADDR, 0);
    chk(rd, 32'h0000_0000);
    xfer(0, sar_seq_pkg::RESULT_ADDR, 0);
    res = rd;
    xfer(1, sar_seq_pkg::RESULT_ADDR, 32'h0000_00C3);
    xfer(0, sar_seq_pkg::RESULT_ADDR, 0);
    chk(rd, res);
    $display("test abort_stop done");
    standby <= 1'h1;
    xfer(1, sar_seq_pkg::MODE_ADDR, 32'h0000_00A0);
    wait_irq();
    chk(32'(n), 32'h0000_0190);
    chk(32'(busy), 32'h0000_0000);
    standby <= 1'h0;
    wait_irq();
    chk(32'(n >= 70 && n <= 78), 32'h0000_0001);
    $display("test standby done");
    end_sim();
  end
endmodule : sar_adc_conversion_sequencer_test

// ### verification/sar_analog_model.sv
// Behavioural analog front end: sample-hold and comparator
`timescale 1ns/1ps
module sar_analog_model (
  input wire logic clk_sys,
  input sar_seq_pkg::analog_ctrl_type analog_ctrl,
  input wire logic [47:0] levels,
  output logic cmp_ge
);
  logic [7:0] held_ff;
  // Track the selected input while sampling, hold it afterwards
  always_ff @(posedge clk_sys) begin
    if (analog_ctrl.sample_hold) begin
      held_ff <= levels[analog_ctrl.channel*8 +: 8];
    end
  end
  // Level already carries the half-step ladder offset
  assign cmp_ge = held_ff >= analog_ctrl.trial_code;
endmodule : sar_analog_model
